// ===== hw/sdram_device.sv
// Command, burst and data-pin logic of a 64-bit four-bank DRAM module
`include "sdram_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module sdram_device #(
    parameter int STORE_AW = 12
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic [`SDRAM_ROW_W-1:0] addr,
    input wire logic [`SDRAM_BA_W-1:0] ba,
    input wire logic [`SDRAM_LANES-1:0] byte_lane_mask,
    input wire logic [`SDRAM_DQ_W-1:0] dq_in,
    output logic [`SDRAM_DQ_W-1:0] dq_out,
    output logic [`SDRAM_LANES-1:0] dq_oe
);
    localparam int FULL_W = `SDRAM_BA_W + `SDRAM_ROW_W + `SDRAM_COL_W;

    if (STORE_AW < 4 || STORE_AW > FULL_W) begin : g_bad_store
        $error("sdram_device: STORE_AW out of range");
    end

    // Backing store only covers the low address bits, so addresses alias
    function automatic logic [STORE_AW-1:0] store_index(
        input logic [`SDRAM_BA_W-1:0] bank,
        input logic [`SDRAM_ROW_W-1:0] row,
        input logic [`SDRAM_COL_W-1:0] col
    );
        logic [FULL_W-1:0] full;
        full = {bank, row, col};
        return full[STORE_AW-1:0];
    endfunction

    function automatic logic [10:0] burst_beats(input logic [2:0] code);
        case (code)
            `SDRAM_BL_1: return 11'h001;
            `SDRAM_BL_2: return 11'h002;
            `SDRAM_BL_4: return 11'h004;
            `SDRAM_BL_8: return 11'h008;
            `SDRAM_BL_FULL: return 11'h400;
            default: return 11'h001;
        endcase
    endfunction

    // Sequential order, wrapping inside the burst-aligned block
    function automatic logic [`SDRAM_COL_W-1:0] next_col(
        input logic [`SDRAM_COL_W-1:0] col,
        input logic [2:0] code
    );
        logic [`SDRAM_COL_W-1:0] m;
        m = 10'(burst_beats(code) - 11'h001);
        return (col & ~m) | ((col + 10'h001) & m);
    endfunction

    sdram_cmd_if cmd_bus ();

    logic cke_reg, cke_next;
    logic edge_ok;
    logic selfref_reg, selfref_next;
    logic cmd_ok;

    logic cl3_reg, cl3_next;
    logic [2:0] bl_code_reg, bl_code_next;
    logic single_wr_reg, single_wr_next;

    logic [`SDRAM_BANKS-1:0] bank_open_reg, bank_open_next;
    logic [`SDRAM_ROW_W-1:0] bank_row_reg [`SDRAM_BANKS];
    logic [`SDRAM_ROW_W-1:0] bank_row_next [`SDRAM_BANKS];

    sdram_pkg::burst_t burst_reg, burst_next;
    logic [`SDRAM_BA_W-1:0] bbank_reg, bbank_next;
    logic [`SDRAM_COL_W-1:0] bcol_reg, bcol_next;
    logic [10:0] bleft_reg, bleft_next;
    logic bautopre_reg, bautopre_next;
    logic bfull_reg, bfull_next;

    logic wr_en, rd_en;
    logic [STORE_AW-1:0] acc_idx;
    logic [`SDRAM_COL_W-1:0] acc_col;
    logic [`SDRAM_BA_W-1:0] acc_bank;
    logic [10:0] beats;

    logic [`SDRAM_DQ_W-1:0] store_mem [2**STORE_AW];
    logic mem_v_reg, mem_v_next;
    logic [`SDRAM_DQ_W-1:0] mem_d_reg;
    logic mem_load;
    logic dly_v_reg, dly_v_next;
    logic [`SDRAM_DQ_W-1:0] dly_d_reg, dly_d_next;
    logic dly_ready;

    logic buf_in_valid, buf_in_ready, buf_out_valid;
    logic [`SDRAM_DQ_W-1:0] buf_in_data, buf_out_data;

    logic [`SDRAM_LANES-1:0] mask1_reg, mask1_next, mask2_reg, mask2_next;
    logic [`SDRAM_DQ_W-1:0] dq_out_reg, dq_out_next;
    logic [`SDRAM_LANES-1:0] dq_oe_reg, dq_oe_next;

    assign edge_ok = cke_reg;

    sdram_cmd_decode u_decode (
        .edge_ok(edge_ok),
        .cs_n(cs_n),
        .ras_n(ras_n),
        .cas_n(cas_n),
        .we_n(we_n),
        .addr(addr),
        .ba(ba),
        .port(cmd_bus.decoder)
    );

    // Command and burst control
    always_comb begin
        cke_next = cke;
        selfref_next = selfref_reg;
        cl3_next = cl3_reg;
        bl_code_next = bl_code_reg;
        single_wr_next = single_wr_reg;
        bank_open_next = bank_open_reg;
        bank_row_next = bank_row_reg;
        burst_next = burst_reg;
        bbank_next = bbank_reg;
        bcol_next = bcol_reg;
        bleft_next = bleft_reg;
        bautopre_next = bautopre_reg;
        bfull_next = bfull_reg;
        wr_en = 1'b0;
        rd_en = 1'b0;
        acc_col = bcol_reg;
        acc_bank = bbank_reg;
        beats = burst_beats(bl_code_reg);
        // Commands are void while self refreshing; leaving needs cke high
        cmd_ok = cmd_bus.valid && !selfref_reg;
        if (selfref_reg && cke) begin
            selfref_next = 1'b0;
        end

        // A burst in progress moves one beat per valid edge
        if (edge_ok && burst_reg != sdram_pkg::BURST_IDLE) begin
            rd_en = burst_reg == sdram_pkg::BURST_READ;
            wr_en = burst_reg == sdram_pkg::BURST_WRITE;
        end

        if (cmd_ok) begin
            case (cmd_bus.cmd)
                sdram_pkg::CMD_ACTIVATE: begin
                    bank_open_next[cmd_bus.bank] = 1'b1;
                    bank_row_next[cmd_bus.bank] = cmd_bus.addr;
                end
                sdram_pkg::CMD_READ, sdram_pkg::CMD_WRITE: begin
                    // A new column command cuts the running burst short
                    acc_col = cmd_bus.addr[`SDRAM_COL_W-1:0];
                    acc_bank = cmd_bus.bank;
                    rd_en = cmd_bus.cmd == sdram_pkg::CMD_READ;
                    wr_en = cmd_bus.cmd == sdram_pkg::CMD_WRITE;
                    if (wr_en && single_wr_reg) begin
                        beats = 11'h001;
                    end
                    burst_next = rd_en ? sdram_pkg::BURST_READ : sdram_pkg::BURST_WRITE;
                    bbank_next = cmd_bus.bank;
                    bautopre_next = cmd_bus.addr[`SDRAM_AUTOPRE_BIT];
                    bfull_next = bl_code_reg == `SDRAM_BL_FULL && !(wr_en && single_wr_reg);
                    bleft_next = beats;
                end
                sdram_pkg::CMD_PRECHARGE: begin
                    if (cmd_bus.addr[`SDRAM_PRE_ALL_BIT]) begin
                        bank_open_next = '0;
                        burst_next = sdram_pkg::BURST_IDLE;
                        rd_en = 1'b0;
                        wr_en = 1'b0;
                    end else begin
                        bank_open_next[cmd_bus.bank] = 1'b0;
                        if (cmd_bus.bank == bbank_reg) begin
                            burst_next = sdram_pkg::BURST_IDLE;
                            rd_en = 1'b0;
                            wr_en = 1'b0;
                        end
                    end
                end
                sdram_pkg::CMD_BURST_STOP: begin
                    burst_next = sdram_pkg::BURST_IDLE;
                    rd_en = 1'b0;
                    wr_en = 1'b0;
                end
                sdram_pkg::CMD_MODE_SET: begin
                    bl_code_next = cmd_bus.addr[`SDRAM_MODE_BL_LSB +: 3];
                    cl3_next = cmd_bus.addr[`SDRAM_MODE_CL_LSB +: 3] == `SDRAM_CL3_CODE;
                    single_wr_next = cmd_bus.addr[`SDRAM_MODE_SINGLE_WR_BIT];
                end
                sdram_pkg::CMD_REFRESH: begin
                    // Refresh taken with cke low enters self refresh
                    if (!cke) begin
                        selfref_next = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // Count down the beat just served and close the burst when done
        if ((rd_en || wr_en) && burst_next != sdram_pkg::BURST_IDLE) begin
            bcol_next = next_col(acc_col, bl_code_reg);
            if (burst_next == burst_reg && !(cmd_ok && (cmd_bus.cmd == sdram_pkg::CMD_READ
                    || cmd_bus.cmd == sdram_pkg::CMD_WRITE))) begin
                bleft_next = bleft_reg;
            end
            if (!bfull_next) begin
                bleft_next = bleft_next - 11'h001;
            end
            if (bleft_next == 11'h000 && !bfull_next) begin
                burst_next = sdram_pkg::BURST_IDLE;
                if (bautopre_next) begin
                    bank_open_next[bbank_next] = 1'b0;
                end
            end
        end
        acc_idx = store_index(acc_bank, bank_row_reg[acc_bank], acc_col);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cke_reg <= 1'b1;
            selfref_reg <= 1'b0;
            cl3_reg <= `SDRAM_MODE_CL_RESET;
            bl_code_reg <= `SDRAM_MODE_BL_RESET;
            single_wr_reg <= `SDRAM_MODE_SINGLE_WR_RESET;
            bank_open_reg <= '0;
            for (int b = 0; b < `SDRAM_BANKS; b++) begin
                bank_row_reg[b] <= '0;
            end
            burst_reg <= sdram_pkg::BURST_IDLE;
            bbank_reg <= '0;
            bcol_reg <= '0;
            bleft_reg <= '0;
            bautopre_reg <= 1'b0;
            bfull_reg <= 1'b0;
        end else begin
            cke_reg <= cke_next;
            selfref_reg <= selfref_next;
            cl3_reg <= cl3_next;
            bl_code_reg <= bl_code_next;
            single_wr_reg <= single_wr_next;
            bank_open_reg <= bank_open_next;
            bank_row_reg <= bank_row_next;
            burst_reg <= burst_next;
            bbank_reg <= bbank_next;
            bcol_reg <= bcol_next;
            bleft_reg <= bleft_next;
            bautopre_reg <= bautopre_next;
            bfull_reg <= bfull_next;
        end
    end

    // Store write with lane masks, and the first read stage
    always_ff @(posedge clk) begin
        for (int l = 0; l < `SDRAM_LANES; l++) begin
            if (wr_en && !byte_lane_mask[l]) begin
                store_mem[acc_idx][l*8 +: 8] <= dq_in[l*8 +: 8];
            end
        end
        if (mem_load) begin
            mem_d_reg <= store_mem[acc_idx];
        end
    end

    // Read pipeline; the latency-3 stage is skipped at latency 2
    always_comb begin
        dly_ready = !dly_v_reg || buf_in_ready;
        mem_load = !mem_v_reg || (cl3_reg ? dly_ready : buf_in_ready);
        mem_v_next = mem_load ? rd_en : mem_v_reg;
        dly_v_next = dly_v_reg;
        dly_d_next = dly_d_reg;
        if (!cl3_reg) begin
            dly_v_next = 1'b0;
        end else if (dly_ready) begin
            dly_v_next = mem_v_reg;
            dly_d_next = mem_d_reg;
        end
        buf_in_valid = cl3_reg ? dly_v_reg : mem_v_reg;
        buf_in_data = cl3_reg ? dly_d_reg : mem_d_reg;
    end

    sdram_pair_buffer #(
        .WIDTH(`SDRAM_DQ_W),
        .DEPTH(2)
    ) u_read_buffer (
        .clk(clk),
        .nrst(nrst),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(buf_in_data),
        .out_valid(buf_out_valid),
        .out_ready(edge_ok),
        .out_data(buf_out_data)
    );

    // Pin stage: a suspended edge holds the pins and the mask delay line
    always_comb begin
        mask1_next = mask1_reg;
        mask2_next = mask2_reg;
        dq_out_next = dq_out_reg;
        dq_oe_next = dq_oe_reg;
        if (edge_ok) begin
            mask1_next = byte_lane_mask;
            mask2_next = mask1_reg;
            dq_out_next = buf_out_valid ? buf_out_data : dq_out_reg;
            // No word left after a cut burst: all lanes float
            dq_oe_next = buf_out_valid ? ~mask2_reg : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mem_v_reg <= 1'b0;
            dly_v_reg <= 1'b0;
            dly_d_reg <= '0;
            mask1_reg <= '0;
            mask2_reg <= '0;
            dq_out_reg <= '0;
            dq_oe_reg <= '0;
        end else begin
            mem_v_reg <= mem_v_next;
            dly_v_reg <= dly_v_next;
            dly_d_reg <= dly_d_next;
            mask1_reg <= mask1_next;
            mask2_reg <= mask2_next;
            dq_out_reg <= dq_out_next;
            dq_oe_reg <= dq_oe_next;
        end
    end

    assign dq_out = dq_out_reg;
    assign dq_oe = dq_oe_reg;
endmodule // sdram_device
`default_nettype wire

// ===== hw/sdram_regs.svh
// Pin widths, field positions and cycle figures of the DRAM module
`ifndef SDRAM_REGS_SVH
`define SDRAM_REGS_SVH

`define SDRAM_ROW_W 13
`define SDRAM_COL_W 10
`define SDRAM_BA_W 2
`define SDRAM_BANKS 4
`define SDRAM_DQ_W 64
`define SDRAM_LANES 8

`define SDRAM_PRE_ALL_BIT 10
`define SDRAM_AUTOPRE_BIT 10
`define SDRAM_MODE_BL_LSB 0
`define SDRAM_MODE_CL_LSB 4
`define SDRAM_MODE_SINGLE_WR_BIT 9
`define SDRAM_BL_1 3'h0
`define SDRAM_BL_2 3'h1
`define SDRAM_BL_4 3'h2
`define SDRAM_BL_8 3'h3
`define SDRAM_BL_FULL 3'h7
`define SDRAM_CL3_CODE 3'h3

`define SDRAM_MODE_CL_RESET 1'b0
`define SDRAM_MODE_BL_RESET 3'h0
`define SDRAM_MODE_SINGLE_WR_RESET 1'b0

// Cycle figures kept by the device itself
`define SDRAM_MASK_TO_READ_DATA_LATENCY 2
`define SDRAM_MASK_TO_WRITE_DATA_LATENCY 0
`define SDRAM_WRITE_TO_DATA_LATENCY 0
`define SDRAM_CLOCK_ENABLE_TO_DISABLE_CYCLES 1
`define SDRAM_SELECT_TO_CMD_DISABLE_CYCLES 0
`define SDRAM_COLUMN_TO_COLUMN_CYCLES 1
`define SDRAM_PRECHARGE_TO_FLOAT_CYCLES_CL2 2
`define SDRAM_PRECHARGE_TO_FLOAT_CYCLES_CL3 3

// Cycle figures that the controller keeps
`define SDRAM_ACT_TO_COLUMN_CYCLES_CL2 2
`define SDRAM_ACT_TO_COLUMN_CYCLES_CL3 3
`define SDRAM_ACT_TO_ACT_SAME_BANK_CYCLES_CL2 8
`define SDRAM_ACT_TO_ACT_SAME_BANK_CYCLES_CL3 9
`define SDRAM_ACT_TO_PRECHARGE_CYCLES 6
`define SDRAM_PRECHARGE_TO_ACT_CYCLES_CL2 2
`define SDRAM_PRECHARGE_TO_ACT_CYCLES_CL3 3
`define SDRAM_WRITE_RECOVERY_CYCLES 2
`define SDRAM_ACT_TO_ACT_OTHER_BANK_CYCLES 2
`define SDRAM_SELFREFRESH_EXIT_CYCLES 1
`define SDRAM_SELFREFRESH_EXIT_TO_CMD_CYCLES_CL2 8
`define SDRAM_SELFREFRESH_EXIT_TO_CMD_CYCLES_CL3 9
`define SDRAM_LAST_WRITE_TO_ACT_AUTOPRE_CYCLES_CL2 4
`define SDRAM_LAST_WRITE_TO_ACT_AUTOPRE_CYCLES_CL3 5
`define SDRAM_LAST_READ_TO_ACT_AUTOPRE_CYCLES 1
`define SDRAM_EARLY_PRECHARGE_OFFSET_CL2 (-1)
`define SDRAM_EARLY_PRECHARGE_OFFSET_CL3 (-2)
`define SDRAM_MODE_SET_TO_ACT_CYCLES 2
`define SDRAM_POWERDOWN_EXIT_TO_CMD_CYCLES 1

`endif

// ===== hw/sdram_pkg.sv
// Command and burst state types of the DRAM module
package sdram_pkg;
    typedef enum logic [3:0] {
        CMD_DESELECT,
        CMD_NOP,
        CMD_ACTIVATE,
        CMD_READ,
        CMD_WRITE,
        CMD_PRECHARGE,
        CMD_REFRESH,
        CMD_MODE_SET,
        CMD_BURST_STOP
    } cmd_t;

    typedef enum logic [1:0] {
        BURST_IDLE,
        BURST_READ,
        BURST_WRITE
    } burst_t;
endpackage

// ===== hw/sdram_cmd_if.sv
// Decoded command passed from the pin decoder to the core
`timescale 1ns/1ns
`default_nettype none
interface sdram_cmd_if;
    logic valid;
    sdram_pkg::cmd_t cmd;
    logic [1:0] bank;
    logic [12:0] addr;
    modport decoder (output valid, output cmd, output bank, output addr);
    modport core (input valid, input cmd, input bank, input addr);
endinterface
`default_nettype wire

// ===== hw/sdram_cmd_decode.sv
// Command pin decoder of the DRAM module
`timescale 1ns/1ns
`default_nettype none
module sdram_cmd_decode (
    input wire logic edge_ok,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [12:0] addr,
    input wire logic [1:0] ba,
    sdram_cmd_if.decoder port
);
    always_comb begin
        port.addr = addr;
        port.bank = ba;
        port.valid = edge_ok && !cs_n;
        if (cs_n) begin
            port.cmd = sdram_pkg::CMD_DESELECT;
        end else begin
            case ({ras_n, cas_n, we_n})
                3'h3: port.cmd = sdram_pkg::CMD_ACTIVATE;
                3'h5: port.cmd = sdram_pkg::CMD_READ;
                3'h4: port.cmd = sdram_pkg::CMD_WRITE;
                3'h2: port.cmd = sdram_pkg::CMD_PRECHARGE;
                3'h1: port.cmd = sdram_pkg::CMD_REFRESH;
                3'h0: port.cmd = sdram_pkg::CMD_MODE_SET;
                3'h6: port.cmd = sdram_pkg::CMD_BURST_STOP;
                default: port.cmd = sdram_pkg::CMD_NOP;
            endcase
        end
    end
endmodule // sdram_cmd_decode
`default_nettype wire

// ===== hw/sdram_pair_buffer.sv
// Small elastic buffer in the read data path
`timescale 1ns/1ns
`default_nettype none
module sdram_pair_buffer #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("sdram_pair_buffer: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] slot [DEPTH];
    logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [PW:0] count_reg, count_next;
    logic push, pop;

    // A full buffer still accepts when the head leaves in the same cycle
    always_comb begin
        out_valid = count_reg != '0;
        out_data = slot[rd_ptr_reg];
        in_ready = (count_reg != (PW+1)'(DEPTH)) || out_ready;
        pop = out_valid && out_ready;
        push = in_valid && in_ready;
        wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        count_next = count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
        if (push) begin
            slot[wr_ptr_reg] <= in_data;
        end
    end
endmodule // sdram_pair_buffer
`default_nettype wire

// ===== test/sdram_ctrl_model.sv
// Controller-side driver for the DRAM module's command and data pins
`timescale 1ns/1ns
`default_nettype none
module sdram_ctrl_model (
    input wire logic clk,
    output var logic cs_n,
    output var logic ras_n,
    output var logic cas_n,
    output var logic we_n,
    output var logic cke,
    output var logic [12:0] addr,
    output var logic [1:0] ba,
    output var logic [7:0] byte_lane_mask,
    output var logic [63:0] dq_in
);
    initial begin
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = 3'h7;
        cke = 1'b1;
        addr = 13'h0000;
        ba = 2'h0;
        byte_lane_mask = 8'h00;
        dq_in = 64'h0;
    end

    // One command per edge; the caller keeps spacing with idle
    task automatic cmd(input logic sel_n, input logic [2:0] c, input logic [1:0] b,
        input logic [12:0] a, input logic [63:0] d, input logic [7:0] m);
        @(posedge clk);
        cs_n <= sel_n;
        {ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        dq_in <= d;
        byte_lane_mask <= m;
        cke <= 1'b1;
    endtask

    // Released data lines flip every cycle so stale data never looks valid
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            cs_n <= 1'b1;
            {ras_n, cas_n, we_n} <= 3'h7;
            dq_in <= ~dq_in;
        end
    endtask

    task automatic suspend();
        @(posedge clk);
        cke <= 1'b0;
        cs_n <= 1'b1;
    endtask

    // Refresh with cke low; cke stays low until the next cmd raises it
    task automatic self_refresh();
        @(posedge clk);
        cs_n <= 1'b0;
        {ras_n, cas_n, we_n} <= 3'h1;
        cke <= 1'b0;
    endtask
endmodule // sdram_ctrl_model
`default_nettype wire

// ===== test/sdram_device_asserts.sv
// Port-level timing checks of the DRAM module
`timescale 1ns/1ns
`default_nettype none
module sdram_device_asserts #(
    parameter int STORE_AW = 12
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic [12:0] addr,
    input wire logic [1:0] ba,
    input wire logic [7:0] byte_lane_mask,
    input wire logic [63:0] dq_in,
    input wire logic [63:0] dq_out,
    input wire logic [7:0] dq_oe
);
    logic cke_q;
    logic cl3_reg;
    logic cl3_next;
    logic bl1_reg;
    logic bl1_next;
    logic [3:0] cke_hist;
    wire logic take = nrst && cke_q && !cs_n;
    wire logic rd = take && ({ras_n, cas_n, we_n} == 3'h5);
    wire logic pre_all = take && ({ras_n, cas_n, we_n} == 3'h2) && addr[10];
    wire logic mode = take && ({ras_n, cas_n, we_n} == 3'h0);

    always_comb begin
        cl3_next = cl3_reg;
        bl1_next = bl1_reg;
        if (mode) begin
            cl3_next = (addr[6:4] == 3'h3);
            bl1_next = !(addr[2:0] inside {3'h1, 3'h2, 3'h3, 3'h7});
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cke_q <= 1'b1;
            cl3_reg <= 1'b0;
            bl1_reg <= 1'b1;
            cke_hist <= 4'hf;
        end else begin
            cke_q <= cke;
            cl3_reg <= cl3_next;
            bl1_reg <= bl1_next;
            cke_hist <= {cke_hist[2:0], cke};
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_mask_lanes_cl2: assert property (rd && !cl3_reg && cke ##1 cke
        |-> ##2 dq_oe == ~$past(byte_lane_mask, 3)) else $error("lane enables wrong at CL2");
    a_mask_lanes_cl3: assert property (rd && cl3_reg && cke ##1 cke[*2]
        |-> ##2 dq_oe == ~$past(byte_lane_mask, 3)) else $error("lane enables wrong at CL3");
    // Suspends are excluded since the buffer may deliver late after one
    a_oe_cause: assert property ((&cke_hist) && $rose(|dq_oe)
        |-> (cl3_reg ? $past(rd, 4) : $past(rd, 3))) else $error("output without a read");
    a_float_cl2: assert property (pre_all && !cl3_reg && cke ##1 cke
        |-> ##2 dq_oe == 8'h00) else $error("no float after precharge at CL2");
    a_float_cl3: assert property (pre_all && cl3_reg && cke ##1 cke[*2]
        |-> ##2 dq_oe == 8'h00) else $error("no float after precharge at CL3");
    a_cke_freeze: assert property (!cke |-> ##2 $stable(dq_oe) && $stable(dq_out))
        else $error("pins moved on a void edge");
    a_column_b2b: assert property (rd && !cl3_reg && cke ##1 rd && cke ##1 cke
        |-> ##1 dq_oe == ~$past(byte_lane_mask, 3) ##1 dq_oe == ~$past(byte_lane_mask, 3))
        else $error("back to back reads lost a beat");
    a_single_beat: assert property (rd && !cl3_reg && bl1_reg && cke ##1 !rd && cke
        ##1 cke ##1 cke |-> ##1 dq_oe == 8'h00) else $error("single beat burst overran");
endmodule // sdram_device_asserts
`default_nettype wire

// ===== test/tb_sdram_device.sv
// Self-checking bench for the DRAM module command and data pins
`timescale 1ns/1ns
`default_nettype none
module tb_sdram_device;
    localparam logic [2:0] op_act = 3'h3;
    localparam logic [2:0] op_rd = 3'h5;
    localparam logic [2:0] op_wr = 3'h4;
    localparam logic [2:0] op_pre = 3'h2;
    localparam logic [2:0] op_mode = 3'h0;
    localparam logic [63:0] word_a = 64'h0123_4567_89ab_cdef;
    localparam logic [63:0] word_b = 64'hfedc_ba98_7654_3210;
    localparam logic [63:0] merged = {word_b[63:32], word_a[31:0]};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    wire logic cs_n, ras_n, cas_n, we_n, cke;
    wire logic [12:0] addr;
    wire logic [1:0] ba;
    wire logic [7:0] byte_lane_mask, dq_oe;
    wire logic [63:0] dq_in, dq_out, dq;
    int errors = 0;
    int cmp_count = 0;

    always #10 clk = ~clk;

    for (genvar l = 0; l < 8; l++) begin : g_lane
        assign dq[8*l +: 8] = dq_oe[l] ? dq_out[8*l +: 8] : 8'hzz;
    end

    sdram_ctrl_model ctrl (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .cke(cke), .addr(addr), .ba(ba), .byte_lane_mask(byte_lane_mask),
        .dq_in(dq_in));
    sdram_device #(.STORE_AW(12)) dut (.clk(clk), .nrst(nrst), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke), .addr(addr), .ba(ba),
        .byte_lane_mask(byte_lane_mask), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Let the edge's updates land before looking at the pins
    task automatic settle(input int n);
        ctrl.idle(n);
        #1;
    endtask

    task automatic t_write_mask();
        ctrl.cmd(1'b0, op_mode, 2'h0, 13'h0000, 64'h0, 8'h00);
        ctrl.idle(1);
        ctrl.cmd(1'b0, op_act, 2'h1, 13'h0000, 64'h0, 8'h00);
        ctrl.idle(1);
        ctrl.cmd(1'b0, op_wr, 2'h1, 13'h0001, word_a, 8'h00);
        ctrl.cmd(1'b0, op_wr, 2'h1, 13'h0001, word_b, 8'h0f);
        ctrl.cmd(1'b0, op_rd, 2'h1, 13'h0001, 64'h0, 8'h01);
        ctrl.cmd(1'b0, op_rd, 2'h1, 13'h0001, 64'h0, 8'h80);
        settle(2);
        check("first beat", {merged[63:8], 8'hzz}, dq);
        settle(1);
        check("second beat", {8'hzz, merged[55:0]}, dq);
        settle(1);
        check("oe after burst", 64'h0, {56'h0, dq_oe});
    endtask

    task automatic t_early_pre();
        ctrl.cmd(1'b0, op_pre, 2'h1, 13'h0000, 64'h0, 8'h00);
        ctrl.idle(2);
        ctrl.cmd(1'b0, op_mode, 2'h0, 13'h0032, 64'h0, 8'h00);
        ctrl.idle(1);
        ctrl.cmd(1'b0, op_act, 2'h1, 13'h0000, 64'h0, 8'h00);
        ctrl.idle(5);
        ctrl.cmd(1'b0, op_rd, 2'h1, 13'h0001, 64'h0, 8'h00);
        ctrl.cmd(1'b0, op_pre, 2'h3, 13'h0400, 64'h0, 8'h70);
        settle(2);
        check("cl3 not yet", 64'h0, {56'h0, dq_oe});
        settle(1);
        check("cl3 word", {merged[63:56], 24'hzzzzzz, merged[31:0]}, dq);
        settle(1);
        check("float after pre", 64'h0, {56'h0, dq_oe});
    endtask

    task automatic t_ignore();
        ctrl.cmd(1'b0, op_mode, 2'h0, 13'h0208, 64'h0, 8'h00);
        ctrl.idle(1);
        ctrl.cmd(1'b0, op_act, 2'h1, 13'h1804, 64'h0, 8'h00);
        ctrl.idle(1);
        ctrl.cmd(1'b1, op_wr, 2'h1, 13'h0001, ~word_b, 8'h00);
        ctrl.suspend();
        ctrl.cmd(1'b0, op_wr, 2'h1, 13'h0001, ~word_a, 8'h00);
        ctrl.cmd(1'b0, op_rd, 2'h1, 13'h0401, 64'h0, 8'h00);
        settle(3);
        check("ignored writes", merged, dq);
        ctrl.cmd(1'b0, op_act, 2'h1, 13'h0000, 64'h0, 8'h00);
        ctrl.idle(1);
        ctrl.cmd(1'b0, op_act, 2'h2, 13'h0000, 64'h0, 8'h00);
        ctrl.cmd(1'b0, op_wr, 2'h1, 13'h0401, word_b, 8'h0f);
        ctrl.idle(4);
        ctrl.cmd(1'b0, op_act, 2'h1, 13'h0000, 64'h0, 8'h00);
        ctrl.idle(5);
        ctrl.cmd(1'b0, op_pre, 2'h0, 13'h0400, 64'h0, 8'h00);
        settle(3);
        check("idle after pre", 64'h0, {56'h0, dq_oe});
        ctrl.self_refresh();
        ctrl.idle(2);
        ctrl.cmd(1'b1, 3'h7, 2'h0, 13'h0000, 64'h0, 8'h00);
        ctrl.idle(8);
        ctrl.cmd(1'b0, op_act, 2'h1, 13'h0000, 64'h0, 8'h00);
        ctrl.idle(1);
        ctrl.cmd(1'b0, op_rd, 2'h1, 13'h0001, 64'h0, 8'h00);
        settle(3);
        check("after self refresh", merged, dq);
    endtask

    task automatic summarize();
        $display("Comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_write_mask();
        t_early_pre();
        t_ignore();
        summarize();
    end

    // The scenarios need 82 cycles, well under the 1000-cycle watchdog
    initial begin
        repeat (1000) @(posedge clk);
        errors++;
        $display("Error watchdog expected done seen hang");
        summarize();
    end
endmodule // tb_sdram_device

bind sdram_device sdram_device_asserts #(.STORE_AW(STORE_AW)) chk (.clk(clk), .nrst(nrst),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke), .addr(addr),
    .ba(ba), .byte_lane_mask(byte_lane_mask), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe));
`default_nettype wire
